// ---- lsfc_pkg.sv ----
package lsfc_pkg;
	// access sizes
	typedef enum logic [1:0]
	{
		LSFC_SIZE_BYTE = 2'h0,
		LSFC_SIZE_WORD = 2'h1,
		LSFC_SIZE_LONG = 2'h2
	} lsfc_size_t;

	localparam logic [31:0] LSFC_PRIV_BASE = 32'hfc000000;
	localparam logic [31:0] LSFC_PRIV_LAST = 32'hffffffff;
	localparam logic LSFC_ENDIAN_RESET = 1'h0;
	localparam int LSFC_WORD_BITS = 32;
	localparam int LSFC_HALF_BITS = 16;
	localparam int LSFC_BYTE_BITS = 8;
endpackage

// ---- lsfc_checker.sv ----
`timescale 1ns/1ps
// How it works
// - user access to top area faults
// - translated user access to registers allowed
// - register operands are always 32 bits
// - byte and word loads sign-extend
// - byte, word and longword sizes supported
// - misaligned word or longword faults
// - bytes allowed at any address
// - endian pin sampled a few clocks after reset release, high little
// - byte order fixed until next reset
// - bit 31 most, bit 0 least significant
module lsfc_checker
(
	input wire logic clk,
	input wire logic rst,
	// endian strap pin
	input wire logic endian_select_pin,
	// pipeline request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [1:0] req_size,
	input wire logic [31:0] req_addr,
	input wire logic req_user,
	input wire logic req_translated,
	input wire logic [31:0] req_wdata,
	// pipeline answer
	output logic rsp_valid,
	output logic rsp_addr_error,
	output logic [31:0] rsp_rdata,
	output logic little_endian,
	// memory bus
	output logic mem_valid,
	output logic mem_write,
	output logic [1:0] mem_size,
	output logic [31:0] mem_addr,
	output logic [3:0] mem_be,
	output logic [31:0] mem_wdata,
	input wire logic mem_done,
	input wire logic [31:0] mem_rdata
);
	typedef enum logic [1:0]
	{
		LSFC_IDLE = 2'h0,
		LSFC_BUS = 2'h1,
		LSFC_DONE = 2'h3
	} lsfc_state_t;

	lsfc_state_t state_reg, state_next;
	logic [2:0] strap_sync_reg;
	logic strap_taken_reg;
	logic little_reg;
	logic [2:0] strap_fill_reg;
	logic err_reg;
	logic [31:0] rdata_reg;
	logic write_reg;
	logic [1:0] size_reg;
	logic [31:0] addr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] be_reg;

	// byte order is latched before any request is accepted
	wire strap_steady = strap_sync_reg[2] == strap_sync_reg[1];
	wire strap_capture = !strap_taken_reg && strap_fill_reg[2] && strap_steady;
	wire accepting = strap_taken_reg;

	// request classification
	wire priv_area = req_addr >= lsfc_pkg::LSFC_PRIV_BASE && req_addr <= lsfc_pkg::LSFC_PRIV_LAST;
	wire priv_fault = req_user && !req_translated && priv_area;
	wire is_word = req_size == 2'(lsfc_pkg::LSFC_SIZE_WORD);
	wire is_long = req_size == 2'(lsfc_pkg::LSFC_SIZE_LONG);
	wire bad_size = req_size == 2'h3;
	wire align_fault = (is_word && req_addr[0]) || (is_long && req_addr[1:0] != 2'h0);
	// an undefined size code is refused like a misaligned access
	wire fault = priv_fault || align_fault || bad_size;
	wire take = req_valid && state_reg == LSFC_IDLE && accepting;

	// lane layout: big endian puts address 0 in bits 31:24
	wire [1:0] lane_b = little_reg ? req_addr[1:0] : ~req_addr[1:0];
	wire [1:0] lane_w = little_reg ? {req_addr[1], 1'b0} : {~req_addr[1], 1'b0};
	wire [3:0] be_calc;
	wire [31:0] wdata_pos;

	// per lane: which part of the store data lands here
	for (genvar i = 0; i < lsfc_pkg::LSFC_WORD_BITS / lsfc_pkg::LSFC_BYTE_BITS; i++)
	begin : g_lane
		wire in_word = lane_w[1] == 1'(i / 2);
		wire in_byte = lane_b == 2'(i);
		wire [7:0] word_part = (i % 2 == 1) ? req_wdata[15:8] : req_wdata[7:0];
		wire [7:0] short_part = is_word ? (in_word ? word_part : 8'h0) : (in_byte ? req_wdata[7:0] : 8'h0);
		assign be_calc[i] = is_long || (is_word ? in_word : in_byte);
		assign wdata_pos[8 * i +: 8] = is_long ? req_wdata[8 * i +: 8] : short_part;
	end

	// read extraction from held request
	wire [1:0] rl_b = little_reg ? addr_reg[1:0] : ~addr_reg[1:0];
	wire [1:0] rl_w = little_reg ? {addr_reg[1], 1'b0} : {~addr_reg[1], 1'b0};
	wire [31:0] rd_b_sh = mem_rdata >> {rl_b, 3'h0};
	wire [31:0] rd_w_sh = mem_rdata >> {rl_w, 3'h0};
	wire [31:0] rd_byte = {{(lsfc_pkg::LSFC_WORD_BITS - lsfc_pkg::LSFC_BYTE_BITS){rd_b_sh[7]}}, rd_b_sh[7:0]};
	wire [31:0] rd_word = {{(lsfc_pkg::LSFC_WORD_BITS - lsfc_pkg::LSFC_HALF_BITS){rd_w_sh[15]}}, rd_w_sh[15:0]};
	wire [31:0] rd_ext = size_reg == 2'(lsfc_pkg::LSFC_SIZE_LONG) ? mem_rdata :
		(size_reg == 2'(lsfc_pkg::LSFC_SIZE_WORD) ? rd_word : rd_byte);
	wire rd_land = state_reg == LSFC_BUS && mem_done && !write_reg;

	// next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			LSFC_IDLE:
				if (take)
					state_next = fault ? LSFC_DONE : LSFC_BUS;
			LSFC_BUS:
				if (mem_done)
					state_next = LSFC_DONE;
			LSFC_DONE:
				state_next = LSFC_IDLE;
			default:
				state_next = LSFC_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_reg <= LSFC_IDLE;
		else
			state_reg <= state_next;
	end

	// strap synchroniser; the fill chain marks when the pin has reached the last flop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			strap_sync_reg <= 3'h0;
			strap_fill_reg <= 3'h0;
		end
		else
		begin
			strap_sync_reg <= {strap_sync_reg[1:0], endian_select_pin};
			strap_fill_reg <= {strap_fill_reg[1:0], 1'b1};
		end
	end

	// one-time capture, held until the next reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			little_reg <= lsfc_pkg::LSFC_ENDIAN_RESET;
			strap_taken_reg <= 1'b0;
		end
		else if (strap_capture)
		begin
			little_reg <= strap_sync_reg[2];
			strap_taken_reg <= 1'b1;
		end
	end

	// fault flag for the answer
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			err_reg <= 1'b0;
		else if (take)
			err_reg <= fault;
	end

	// access attributes held for the bus
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			write_reg <= 1'b0;
			size_reg <= 2'h0;
			addr_reg <= 32'h0;
		end
		else if (take)
		begin
			write_reg <= req_write;
			size_reg <= req_size;
			addr_reg <= req_addr;
		end
	end

	// lane-placed store data and byte enables
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wdata_reg <= 32'h0;
			be_reg <= 4'h0;
		end
		else if (take)
		begin
			wdata_reg <= wdata_pos;
			be_reg <= be_calc;
		end
	end

	// load data lands with the memory's done pulse
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_reg <= 32'h0;
		else if (rd_land)
			rdata_reg <= rd_ext;
	end

	// outputs come straight from registers: state, held request, fault flag, load data and byte order
	assign rsp_valid = state_reg == LSFC_DONE;
	assign rsp_addr_error = err_reg;
	assign rsp_rdata = rdata_reg;
	assign little_endian = little_reg;
	assign mem_valid = state_reg == LSFC_BUS;
	assign mem_write = write_reg;
	assign mem_size = size_reg;
	assign mem_addr = addr_reg;
	assign mem_be = be_reg;
	assign mem_wdata = wdata_reg;
endmodule

// ---- lsfc_sva.sv ----
`timescale 1ns/1ps
module lsfc_sva
(
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic [1:0] req_size,
	input wire logic [31:0] req_addr,
	input wire logic req_user,
	input wire logic req_translated,
	input wire logic rsp_valid,
	input wire logic rsp_addr_error,
	input wire logic little_endian,
	input wire logic mem_valid,
	input wire logic [3:0] mem_be,
	input wire logic mem_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// cycles since reset release, saturating once the byte order is latched
	logic [2:0] up_cnt_reg;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			up_cnt_reg <= 3'h0;
		else if (up_cnt_reg != 3'h4)
			up_cnt_reg <= up_cnt_reg + 3'h1;
	end
	wire up = up_cnt_reg == 3'h4;
	wire tk = up && req_valid && !mem_valid && !rsp_valid;
	wire ok = !req_user || req_translated || req_addr < 32'hfc000000;
	wire mis = req_size == 2'h1 && req_addr[0] || req_size == 2'h2 && req_addr[1:0] != 2'h0;
	property p_priv; tk && !ok |=> rsp_valid && rsp_addr_error; endproperty
	a_priv: assert property (p_priv) else $error("user top area");
	property p_xlat; tk && req_user && req_translated && !mis && req_size != 2'h3 |=> mem_valid; endproperty
	a_xlat: assert property (p_xlat) else $error("translated");
	property p_mis; tk && mis |=> rsp_valid && rsp_addr_error; endproperty
	a_mis: assert property (p_mis) else $error("misaligned");
	property p_byte; tk && ok && req_size == 2'h0 |=> mem_valid && $onehot(mem_be); endproperty
	a_byte: assert property (p_byte) else $error("byte");
	property p_nobus; rsp_valid && rsp_addr_error |-> !mem_valid && !$past(mem_valid); endproperty
	a_nobus: assert property (p_nobus) else $error("fault on bus");
	property p_done; mem_valid && mem_done |=> rsp_valid && !mem_valid && !rsp_addr_error; endproperty
	a_done: assert property (p_done) else $error("done");
	property p_fix; up && $past(up) |-> $stable(little_endian); endproperty
	a_fix: assert property (p_fix) else $error("order moved");
	property p_lane; tk && ok && req_size == 2'h1 && req_addr[1:0] == 2'h2 |=> mem_be == (little_endian ? 4'hc : 4'h3); endproperty
	a_lane: assert property (p_lane) else $error("lanes");
endmodule
bind lsfc_checker lsfc_sva chk_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_size(req_size),
	.req_addr(req_addr), .req_user(req_user), .req_translated(req_translated), .rsp_valid(rsp_valid),
	.rsp_addr_error(rsp_addr_error), .little_endian(little_endian), .mem_valid(mem_valid), .mem_be(mem_be),
	.mem_done(mem_done));

// ---- lsfc_mem_model.sv ----
`timescale 1ns/1ps
module lsfc_mem_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic mem_valid,
	output logic mem_done,
	output logic [31:0] mem_rdata
);
	logic w_reg;
	// one wait state, then done
	always_ff @(posedge clk or posedge rst)
		if (rst)
			w_reg <= 1'h0;
		else
			w_reg <= mem_valid && !mem_done;
	assign mem_done = mem_valid && w_reg;
	assign mem_rdata = mem_done ? 32'h12348765 : 32'hedcb789a;
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("Error %0t %h %h", $time, a, b); end end
module tb_top;
	logic clk = 1'h0, rst = 1'h1, pin = 1'h0, rv = 1'h0, usr = 1'h0, tr = 1'h0, wr = 1'h0;
	logic [1:0] sz = 2'h0;
	logic [31:0] ad = 32'h0, wd = 32'h0;
	wire rsv, rse, le, mv, md, mw;
	wire [1:0] ms;
	wire [3:0] be;
	wire [31:0] rd, mrd, ma, mwd;
	int errors = 0, check_count = 0;
	always #20 clk = ~clk;
	lsfc_checker dut_u (.clk(clk), .rst(rst), .endian_select_pin(pin), .req_valid(rv), .req_write(wr),
		.req_size(sz), .req_addr(ad), .req_user(usr), .req_translated(tr), .req_wdata(wd), .rsp_valid(rsv),
		.rsp_addr_error(rse), .rsp_rdata(rd), .little_endian(le), .mem_valid(mv), .mem_write(mw), .mem_size(ms),
		.mem_addr(ma), .mem_be(be), .mem_wdata(mwd), .mem_done(md), .mem_rdata(mrd));
	lsfc_mem_model mem_u (.clk(clk), .rst(rst), .mem_valid(mv), .mem_done(md), .mem_rdata(mrd));
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic do_reset(input logic p);
		pin <= p;
		rst <= 1'h1;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		repeat (6) @(posedge clk);
	endtask
	task automatic acc(input logic [1:0] s, input logic [31:0] a, input logic u, t, e, input logic [31:0] d);
		int n;
		@(posedge clk);
		{sz, ad, usr, tr, rv} <= {s, a, u, t, 1'h1};
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (rsv !== 1'h1 && n < 20);
		if (rsv !== 1'h1)
		begin
			errors++;
			report_and_stop;
		end
		else
		begin
			`CHK(rse, e)
			if (!e)
				`CHK(rd, d)
			@(posedge clk);
			rv <= 1'h0;
		end
	endtask
	task automatic st(input logic [1:0] s, input logic [31:0] a, d, input logic e, input logic [3:0] b,
		input logic [31:0] w);
		int n;
		logic seen;
		@(posedge clk);
		{sz, ad, usr, tr, wr, wd, rv} <= {s, a, 1'h0, 1'h0, 1'h1, d, 1'h1};
		n = 0;
		seen = 1'h0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
			if (mv === 1'h1 && !seen)
			begin
				seen = 1'h1;
				`CHK({mw, ms, ma}, {1'h1, s, a})
				`CHK({be, mwd}, {b, w})
			end
		end
		while (rsv !== 1'h1 && n < 20);
		if (rsv !== 1'h1)
		begin
			errors++;
			report_and_stop;
		end
		else
		begin
			`CHK(rse, e)
			`CHK(seen, !e)
			@(posedge clk);
			rv <= 1'h0;
			wr <= 1'h0;
		end
	endtask
	task automatic t_big;
		`CHK(le, 1'h0)
		acc(2'h1, 32'h2, 1'h0, 1'h0, 1'h0, 32'hffff8765);
		acc(2'h0, 32'h1, 1'h0, 1'h0, 1'h0, 32'h34);
		acc(2'h2, 32'h0, 1'h0, 1'h0, 1'h0, 32'h12348765);
		acc(2'h1, 32'h1, 1'h0, 1'h0, 1'h1, 32'h0);
		acc(2'h2, 32'h6, 1'h0, 1'h0, 1'h1, 32'h0);
		acc(2'h3, 32'h0, 1'h0, 1'h0, 1'h1, 32'h0);
		acc(2'h0, 32'hfc000010, 1'h1, 1'h0, 1'h1, 32'h0);
		acc(2'h2, 32'hfc000000, 1'h1, 1'h1, 1'h0, 32'h12348765);
		acc(2'h0, 32'h3, 1'h1, 1'h0, 1'h0, 32'h65);
		st(2'h1, 32'h2, 32'h0000abcd, 1'h0, 4'h3, 32'h0000abcd);
		st(2'h0, 32'h1, 32'h0000005a, 1'h0, 4'h4, 32'h005a0000);
		st(2'h2, 32'h4, 32'h11223344, 1'h0, 4'hf, 32'h11223344);
		st(2'h2, 32'h2, 32'h11223344, 1'h1, 4'h0, 32'h0);
		$display("big endian test done");
	endtask
	task automatic t_little;
		do_reset(1'h1);
		`CHK(le, 1'h1)
		acc(2'h1, 32'h2, 1'h0, 1'h0, 1'h0, 32'h1234);
		acc(2'h0, 32'h1, 1'h0, 1'h0, 1'h0, 32'hffffff87);
		st(2'h1, 32'h2, 32'h0000abcd, 1'h0, 4'hc, 32'habcd0000);
		st(2'h0, 32'h3, 32'h0000005a, 1'h0, 4'h8, 32'h5a000000);
		pin <= 1'h0;
		repeat (8) @(posedge clk);
		`CHK(le, 1'h1)
		$display("little endian test done");
	endtask
	initial
	begin
		do_reset(1'h0);
		t_big;
		t_little;
		report_and_stop;
	end
endmodule
